//--- verilog/orms_pkg.sv
// Constants and types for the offset reversal measurement sequencer
package orms_pkg;
   localparam int DATA_W = 24;
   localparam int SETTLE_W = 16;
   localparam int EXC_W = 16;
   localparam int CAL_W = 24;
   localparam logic [15:0] SETTLE_RESET = 16'h0004;
   localparam logic [15:0] EXC_RESET = 16'h0004;
   localparam logic [23:0] CAL_INTERVAL_RESET = 24'h000400;
   localparam int SUBS_MAX = 4;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_SELECT = 4'h1,
      ST_OFS_CONV = 4'h2,
      ST_OFS_WAIT = 4'h3,
      ST_SETTLE = 4'h4,
      ST_CONV = 4'h5,
      ST_WAIT = 4'h6,
      ST_HOLD = 4'h7,
      ST_REVERSE = 4'h8,
      ST_RESULT = 4'h9,
      ST_BG_CONV = 4'ha,
      ST_BG_WAIT = 4'hb
   } seq_state_e;
endpackage

//--- verilog/settle_timer.sv
// Down counter used for settling and excitation hold times
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Control
   input wire logic load_i,
   input wire logic [W-1:0] count_i,
   // Status
   output logic done_o
);
   logic [W-1:0] count;
   logic [W-1:0] next_count;

   always_comb begin
      next_count = count;
      if (load_i) begin
         next_count = count_i;
      end else if (count != '0) begin
         next_count = count - W'(1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign done_o = (count == '0) && !load_i;
endmodule
`default_nettype wire

//--- verilog/offset_reversal_measurement_sequencer.sv
// Measurement sequencer with input and excitation reversal and offset correction
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Input reversal takes normal polarity first, then swapped differential inputs.
// - Opposite-polarity pair reports first minus second, halved.
// - Excitation reversal takes inverted-excitation second reading, subtracts and halves.
// - Both reversals give four readings ordered +/+, -/+, +/-, -/-.
// - Select; excite, settle, convert; invert; invert and swap; invert again.
// - Every reversal is followed by the same settling time as the first.
// - Excitation stays on equally long in each polarity.
// - Single-ended ratiometric without excitation reversal uses calibrated offset.
// - Non-reversed measurements subtract a grounded-input offset value.
// - Differential non-reversed offset comes from background calibration only.
// - Start-offset option converts grounded offset before non-ratiometric single-ended signal conversion.
// - Without start offset, single-ended results without excitation reversal use last stored calibration offset.
// - With every option disabled, measurements still get background calibration offset compensation.
// - Background offset refreshes periodically; measurements use latest stored value.
module offset_reversal_measurement_sequencer
   import orms_pkg::*;
#(
   parameter int unsigned CAL_INTERVAL = CAL_INTERVAL_RESET
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // Instruction
   input wire logic start_i,
   input wire logic differential_i,
   input wire logic ratiometric_i,
   input wire logic input_reverse_enable_i,
   input wire logic excitation_reverse_enable_i,
   input wire logic offset_at_start_enable_i,
   input wire logic [SETTLE_W-1:0] settle_cycles_i,
   input wire logic [EXC_W-1:0] excitation_cycles_i,
   // Converter
   output logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic signed [DATA_W-1:0] conv_data_i,
   // Analog front end
   output logic input_select_o,
   output logic input_swap_o,
   output logic inputs_grounded_o,
   output logic excitation_on_o,
   output logic excitation_negative_o,
   // Result
   output logic busy_o,
   output logic result_valid_o,
   output logic signed [DATA_W-1:0] result_o,
   output logic signed [DATA_W-1:0] bg_offset_o
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      seq_state_e st;
      logic [2:0] sub;
      logic [2:0] subs;
      logic diff;
      logic ofs_start;
      logic rev_in;
      logic rev_exc;
      logic signed [DATA_W+1:0] acc;
      logic signed [DATA_W-1:0] ofs;
      logic signed [DATA_W-1:0] bg_ofs;
      logic [CAL_W-1:0] cal_cnt;
      logic bg_due;
      logic conv_start;
      logic sel;
      logic swap;
      logic gnd;
      logic exc_on;
      logic exc_neg;
      logic busy;
      logic valid;
      logic signed [DATA_W-1:0] result;
   } state_s;

   state_s q;
   state_s d;
   logic tmr_load;
   logic [SETTLE_W-1:0] tmr_count;
   logic tmr_done;

   // Sign of a sub reading from its polarities
   function automatic logic sub_negative(input logic exc_neg, input logic swap);
      return exc_neg ^ swap;
   endfunction

   settle_timer #(.W(SETTLE_W)) u_timer (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .load_i(tmr_load),
      .count_i(tmr_count),
      .done_o(tmr_done)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      d = q;
      tmr_load = 1'b0;
      tmr_count = settle_cycles_i;
      d.conv_start = 1'b0;
      d.valid = 1'b0;
      case (q.st)
         ST_IDLE: begin
            d.busy = 1'b0;
            if (q.bg_due) begin
               d.bg_due = 1'b0;
               d.gnd = 1'b1;
               d.busy = 1'b1;
               d.conv_start = 1'b1;
               d.st = ST_BG_WAIT;
            end else if (start_i) begin
               d.busy = 1'b1;
               d.diff = differential_i;
               // Ratiometric single-ended keeps the calibrated offset
               d.ofs_start = offset_at_start_enable_i && !differential_i
                  && !ratiometric_i;
               d.rev_in = differential_i && input_reverse_enable_i;
               d.rev_exc = ratiometric_i && excitation_reverse_enable_i;
               d.subs = 3'h1;
               if (d.rev_in) begin
                  d.subs = 3'h2;
               end
               if (d.rev_exc) begin
                  d.subs = d.subs << 1;
               end
               d.sub = '0;
               d.acc = '0;
               d.ofs = q.bg_ofs;
               d.sel = 1'b1;
               d.swap = 1'b0;
               d.exc_neg = 1'b0;
               d.st = ST_SELECT;
            end
         end
         ST_BG_WAIT: begin
            if (conv_done_i) begin
               d.bg_ofs = conv_data_i;
               d.gnd = 1'b0;
               d.st = ST_IDLE;
            end
         end
         ST_SELECT: begin
            if (q.ofs_start) begin
               d.gnd = 1'b1;
               d.conv_start = 1'b1;
               d.st = ST_OFS_WAIT;
            end else begin
               d.exc_on = ratiometric_i;
               tmr_load = 1'b1;
               d.st = ST_SETTLE;
            end
         end
         ST_OFS_WAIT: begin
            if (conv_done_i) begin
               d.ofs = conv_data_i;
               d.gnd = 1'b0;
               d.exc_on = ratiometric_i;
               tmr_load = 1'b1;
               d.st = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (tmr_done) begin
               d.conv_start = 1'b1;
               d.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (conv_done_i) begin
               if (sub_negative(q.exc_neg, q.swap)) begin
                  d.acc = q.acc - (DATA_W+2)'(conv_data_i);
               end else begin
                  d.acc = q.acc + (DATA_W+2)'(conv_data_i);
               end
               d.sub = q.sub + 3'h1;
               tmr_load = 1'b1;
               tmr_count = SETTLE_W'(excitation_cycles_i);
               d.st = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // Fixed on-time per polarity
            if (tmr_done) begin
               d.st = (q.sub == q.subs) ? ST_RESULT : ST_REVERSE;
            end
         end
         ST_REVERSE: begin
            if (q.rev_exc) begin
               d.exc_neg = !q.exc_neg;
            end
            // Inputs swap halfway through the sub sequence
            if (q.rev_in && q.sub == (q.subs >> 1)) begin
               d.swap = 1'b1;
            end
            tmr_load = 1'b1;
            d.st = ST_SETTLE;
         end
         ST_RESULT: begin
            d.exc_on = 1'b0;
            d.exc_neg = 1'b0;
            d.swap = 1'b0;
            d.sel = 1'b0;
            d.valid = 1'b1;
            case (q.subs)
               3'h4: d.result = DATA_W'(q.acc >>> 2);
               3'h2: d.result = DATA_W'(q.acc >>> 1);
               default: d.result = DATA_W'(q.acc) - q.ofs;
            endcase
            d.st = ST_IDLE;
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase
      // Periodic background refresh request, set wins over clear
      if (q.cal_cnt == CAL_W'(CAL_INTERVAL - 1)) begin
         d.cal_cnt = '0;
         d.bg_due = 1'b1;
      end else begin
         d.cal_cnt = q.cal_cnt + CAL_W'(1);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign conv_start_o = q.conv_start;
   assign input_select_o = q.sel;
   assign input_swap_o = q.swap;
   assign inputs_grounded_o = q.gnd;
   assign excitation_on_o = q.exc_on;
   assign excitation_negative_o = q.exc_neg;
   assign busy_o = q.busy;
   assign result_valid_o = q.valid;
   assign result_o = q.result;
   assign bg_offset_o = q.bg_ofs;
endmodule
`default_nettype wire

//--- verification/orms_assertions.sv
// Port checker for the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module orms_assertions
   import orms_pkg::*;
(
   input wire logic clk_sys_i, sys_rst_i, differential_i, ratiometric_i,
   input wire logic input_reverse_enable_i, excitation_reverse_enable_i,
   input wire logic offset_at_start_enable_i,
   input wire logic [SETTLE_W-1:0] settle_cycles_i,
   input wire logic conv_start_o, conv_done_i, input_select_o, input_swap_o,
   input wire logic inputs_grounded_o, excitation_on_o, excitation_negative_o,
   input wire logic busy_o, result_valid_o,
   input wire logic signed [DATA_W-1:0] bg_offset_o
);
   logic [3:0] n;
   logic [3:0] n_exp;
   logic [15:0] q;
   logic [19:0] tp, tn;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // Conversions, settle time and excitation time
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !busy_o) begin
         n <= '0;
         tp <= '0;
         tn <= '0;
      end else begin
         n <= n + 4'(conv_start_o && input_select_o);
         tp <= tp + 20'(excitation_on_o && !excitation_negative_o);
         tn <= tn + 20'(excitation_on_o && excitation_negative_o);
      end
      if (sys_rst_i || $changed({input_select_o, input_swap_o, excitation_negative_o,
            excitation_on_o, inputs_grounded_o})) begin
         q <= '0;
      end else if (q != 16'hffff) begin
         q <= q + 16'h1;
      end
   end
   // Expected conversions per instruction
   always_comb begin
      n_exp = 4'h1;
      if (differential_i && input_reverse_enable_i) begin
         n_exp = 4'h2;
      end
      if (ratiometric_i && excitation_reverse_enable_i) begin
         n_exp = n_exp << 1;
      end
      if (!differential_i && !ratiometric_i && offset_at_start_enable_i) begin
         n_exp = n_exp + 4'h1;
      end
   end
   sequence sub_conv_s;
      conv_start_o && input_select_o && !inputs_grounded_o;
   endsequence
   swap_needs_diff_a: assert property (input_swap_o |-> differential_i && input_reverse_enable_i) else $error("swap without input reversal");
   exc_needs_rat_a: assert property (excitation_negative_o |-> ratiometric_i && excitation_reverse_enable_i) else $error("inverted excitation unasked");
   swap_order_a: assert property ($rose(input_swap_o) |-> !excitation_negative_o && $past(excitation_negative_o) == (ratiometric_i && excitation_reverse_enable_i)) else $error("bad reversal order");
   select_first_a: assert property (conv_start_o && !inputs_grounded_o |-> input_select_o && busy_o) else $error("conversion before select");
   settle_equal_a: assert property (sub_conv_s |-> q >= settle_cycles_i) else $error("settle too short");
   exc_time_a: assert property (result_valid_o && ratiometric_i && excitation_reverse_enable_i |-> tp == tn) else $error("unequal excitation time");
   sub_count_a: assert property (result_valid_o |-> n == n_exp) else $error("wrong conversion count");
   diff_no_ground_a: assert property (input_select_o && differential_i |-> !inputs_grounded_o) else $error("grounded during differential");
   start_ofs_a: assert property (conv_start_o && input_select_o && n == 4'h0 && !differential_i && !ratiometric_i && offset_at_start_enable_i |-> inputs_grounded_o) else $error("offset not first");
   bg_store_a: assert property ($changed(bg_offset_o) |-> $past(conv_done_i)) else $error("offset stored without conversion");
endmodule
bind offset_reversal_measurement_sequencer orms_assertions orms_assertions_inst (
   .clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i),
   .differential_i(differential_i),
   .ratiometric_i(ratiometric_i),
   .input_reverse_enable_i(input_reverse_enable_i),
   .excitation_reverse_enable_i(excitation_reverse_enable_i),
   .offset_at_start_enable_i(offset_at_start_enable_i),
   .settle_cycles_i(settle_cycles_i),
   .conv_start_o(conv_start_o),
   .conv_done_i(conv_done_i),
   .input_select_o(input_select_o),
   .input_swap_o(input_swap_o),
   .inputs_grounded_o(inputs_grounded_o),
   .excitation_on_o(excitation_on_o),
   .excitation_negative_o(excitation_negative_o),
   .busy_o(busy_o),
   .result_valid_o(result_valid_o),
   .bg_offset_o(bg_offset_o)
);
`default_nettype wire

//--- verification/orms_front_model.sv
// Converter and front end model
`timescale 1ns/1ps
`default_nettype none
module orms_front_model
   import orms_pkg::*;
(
   input wire logic clk_sys_i, sys_rst_i, conv_start_i, grounded_i, swap_i, neg_i,
   input wire logic signed [DATA_W-1:0] sig_i, ofs_i,
   input wire logic [3:0] lat_i,
   output logic done_o,
   output logic signed [DATA_W-1:0] data_o
);
   logic [3:0] cnt;
   logic signed [DATA_W-1:0] val;
   always_ff @(posedge clk_sys_i) begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (sys_rst_i) begin
         cnt <= '0;
         data_o <= '0;
      end else if (conv_start_i) begin
         cnt <= lat_i;
         val <= grounded_i ? ofs_i : (neg_i ^ swap_i) ? ofs_i - sig_i : ofs_i + sig_i;
      end else if (cnt == 4'h1) begin
         cnt <= '0;
         done_o <= 1'b1;
         data_o <= val;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- verification/offset_reversal_measurement_sequencer_bench.sv
// Self-checking bench for the measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module offset_reversal_measurement_sequencer_bench;
   import orms_pkg::*;
   localparam logic signed [DATA_W-1:0] OFS = 24'h000123;
   logic clk_sys_i = 0, sys_rst_i = 1, start_i = 0, differential_i = 0, ratiometric_i = 0;
   logic input_reverse_enable_i = 0, excitation_reverse_enable_i = 0;
   logic offset_at_start_enable_i = 0;
   logic [15:0] settle_cycles_i = 0, excitation_cycles_i = 1;
   logic [3:0] lat = 1;
   logic signed [DATA_W-1:0] sig = 0, got, conv_data_i, result_o, bg_offset_o;
   logic conv_start_o, conv_done_i, input_select_o, input_swap_o, inputs_grounded_o;
   logic excitation_on_o, excitation_negative_o, busy_o, result_valid_o;
   int n_mismatch = 0, tests_run = 0, cyc = 0, n_conv = 0, seed = 32'hf1df155f;
   offset_reversal_measurement_sequencer #(.CAL_INTERVAL(64)) offset_reversal_measurement_sequencer_inst (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .start_i(start_i),
      .differential_i(differential_i),
      .ratiometric_i(ratiometric_i),
      .input_reverse_enable_i(input_reverse_enable_i),
      .excitation_reverse_enable_i(excitation_reverse_enable_i),
      .offset_at_start_enable_i(offset_at_start_enable_i),
      .settle_cycles_i(settle_cycles_i),
      .excitation_cycles_i(excitation_cycles_i),
      .conv_start_o(conv_start_o),
      .conv_done_i(conv_done_i),
      .conv_data_i(conv_data_i),
      .input_select_o(input_select_o),
      .input_swap_o(input_swap_o),
      .inputs_grounded_o(inputs_grounded_o),
      .excitation_on_o(excitation_on_o),
      .excitation_negative_o(excitation_negative_o),
      .busy_o(busy_o),
      .result_valid_o(result_valid_o),
      .result_o(result_o),
      .bg_offset_o(bg_offset_o)
   );
   orms_front_model orms_front_model_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .conv_start_i(conv_start_o), .grounded_i(inputs_grounded_o), .swap_i(input_swap_o),
      .neg_i(excitation_negative_o), .sig_i(sig), .ofs_i(OFS), .lat_i(lat),
      .done_o(conv_done_i), .data_o(conv_data_i));
   always #2 clk_sys_i = ~clk_sys_i;
   function automatic int subs(logic [4:0] m);
      return (m[0] && m[2] ? 2 : 1) * (m[1] && m[3] ? 2 : 1) + int'(!m[0] && !m[1] && m[4]);
   endfunction
   task automatic check(input logic signed [DATA_W-1:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t seen %0d expected %0d", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (conv_start_o === 1'b1 && input_select_o === 1'b1)
         n_conv++;
      if (cyc == 60000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys_i);
      sys_rst_i <= 0;
      repeat (100) @(posedge clk_sys_i);
      // Every option mix, twice, with random values
      for (int i = 0; i < 64; i++) begin
         @(posedge clk_sys_i);
         {offset_at_start_enable_i, excitation_reverse_enable_i, input_reverse_enable_i,
            ratiometric_i, differential_i} <= i[4:0];
         sig <= 24'($random(seed) % 2000);
         settle_cycles_i <= i[5] ? 16'h0 : 16'($unsigned($random(seed)) % 8);
         excitation_cycles_i <= 16'($unsigned($random(seed)) % 6 + 1);
         lat <= 4'($unsigned($random(seed)) % 9 + 1);
         n_conv = 0;
         start_i <= 1;
         // Hold start until taken; a background conversion may come first
         for (int k = 0; k < 300 && input_select_o !== 1'b1; k++) @(negedge clk_sys_i);
         @(posedge clk_sys_i);
         start_i <= 0;
         for (int k = 0; k < 2000 && result_valid_o !== 1'b1; k++) @(negedge clk_sys_i);
         got = result_o;
         for (int k = 0; k < 300 && busy_o !== 1'b0; k++) @(negedge clk_sys_i);
         check(got, sig);
         check(24'(n_conv), 24'(subs(i[4:0])));
         check(bg_offset_o, OFS);
         $display("test %0d done", i);
      end
      end_sim();
   end
endmodule
`default_nettype wire
